// ### otp_cal_pkg.sv
// Constants for the calibration shift register control block.
// Assumes a 200 MHz system clock and a host-driven serial command link.
package otp_cal_pkg;
    // ----------------------------------------
    // Shift register layout
    // ----------------------------------------
    localparam int SR_BITS = 9;
    localparam int VOP_MSB = 8;
    localparam int VOP_LSB = 4;
    localparam int TC_MSB = 3;
    localparam int TC_LSB = 1;
    localparam int SEAL_POS = 0;
    localparam logic [8:0] SR_RESET = 9'h000;
    // ----------------------------------------
    // Command bytes and fields
    // ----------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [7:0] CMD_CAL_ENTRY = 8'h82;
    localparam logic [7:0] CMD_EXIT_PSAVE = 8'he1;
    localparam logic [4:0] PWR_OPCODE = 5'h05;
    localparam int PWR_OPC_MSB = 7;
    localparam int PWR_OPC_LSB = 3;
    localparam int PWR_FLD_MSB = 2;
    localparam int PWR_FLD_LSB = 1;
    localparam int PWR_TAG_BIT = 0;
    localparam logic [1:0] HV_FIELD_RESET = 2'h0;
    localparam int CONT_BIT = 7;
    localparam int DATA_BIT = 0;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int REFRESH_TIME_US = 5000;
    localparam int CLK_MHZ = 200;
    localparam int REFRESH_CYCLES = REFRESH_TIME_US * CLK_MHZ;
    localparam int CNT_W = 20;
endpackage : otp_cal_pkg

// ### link_if.sv
// Received-byte channel from the link front end to the command logic.
// Assumes both ends run on clk_sys.
interface link_if;
    logic byte_ok;
    logic [7:0] byte_data;
    logic byte_dc;
    logic byte_rw;
    logic sclk_fall;
    modport src (output byte_ok, output byte_data, output byte_dc, output byte_rw, output sclk_fall);
    modport dst (input byte_ok, input byte_data, input byte_dc, input byte_rw, input sclk_fall);
endinterface : link_if

// ### link_rx.sv
// Serial command link front end: synchronises the pins and assembles bytes.
// Assumes the link clock is much slower than clk_sys (80 ns versus 5 ns).
module link_rx (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic link_sclk,
    input wire logic link_sdin,
    input wire logic link_dc,
    input wire logic link_rw,
    input wire logic link_ce_n,
    link_if.src rx
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    // Pin order in the sync vectors: {ce_n, rw, dc, sdin, sclk}
    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic sclk_d;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic byte_ok;
        logic [7:0] byte_data;
        logic byte_dc;
        logic byte_rw;
        logic fall;
    } rx_state_t;

    rx_state_t st_ff;
    rx_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = {link_ce_n, link_rw, link_dc, link_sdin, link_sclk};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sclk_d = st_ff.sync2[0];
        nxt_st.byte_ok = 1'b0;
        nxt_st.fall = st_ff.sclk_d & ~st_ff.sync2[0];
        if (st_ff.sync2[4]) begin
            // Deselect realigns the byte boundary
            nxt_st.cnt = 3'h0;
        end else if (st_ff.sync2[0] & ~st_ff.sclk_d) begin
            nxt_st.shift = {st_ff.shift[6:0], st_ff.sync2[1]};
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == otp_cal_pkg::BIT_CNT_LAST) begin
                nxt_st.byte_ok = 1'b1;
                nxt_st.byte_data = {st_ff.shift[6:0], st_ff.sync2[1]};
                nxt_st.byte_dc = st_ff.sync2[2];
                nxt_st.byte_rw = st_ff.sync2[3];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign rx.byte_ok = st_ff.byte_ok;
    assign rx.byte_data = st_ff.byte_data;
    assign rx.byte_dc = st_ff.byte_dc;
    assign rx.byte_rw = st_ff.byte_rw;
    assign rx.sclk_fall = st_ff.fall;
endmodule : link_rx

// ### otp_calibration_shift_control.sv
// Calibration mode, shift register and refresh control of the OTP slices.
// Assumes a serial command link sampled by clk_sys and OTP cell levels on clk_sys.
//
// What this block does
// - Byte 0x82 as write command enters calibration
// - Calibration mode enables loading and programming
// - Set seal bit makes entry command ignored
// - In calibration every write command byte (dc low) is shift data; dc-high bytes are ignored
// - D7 one stays, zero leaves calibration
// - Reset leaves calibration mode
// - Data bytes sent as commands; two bits used
// - D0 shifts in on link clock fall
// - Refresh reloads every bit from cells
// - Refresh lasts 5 ms; commands still run
// - Power-control command starts refresh outside power-save
// - In power-save store field, skip refresh
// - Contents partial until all bits shifted
// - Nine bits, offset first, seal last, MSB first
// - Entry refused until a refresh completed
// - All nine bits clear on reset
module otp_calibration_shift_control #(
    parameter int REFRESH_CYCLES = otp_cal_pkg::REFRESH_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic link_sclk,
    input wire logic link_sdin,
    input wire logic link_dc,
    input wire logic link_rw,
    input wire logic link_ce_n,
    input wire logic extended_set_select,
    input wire logic [8:0] otp_cell_data,
    output logic calibration_entry_mode,
    output logic cal_load_en,
    output logic otp_prog_en,
    output logic [4:0] lcd_voltage_offset_code,
    output logic [2:0] temp_coeff_default,
    output logic seal_bit,
    output logic [8:0] cal_shift_reg,
    output logic [1:0] hv_gen_power_field,
    output logic power_save,
    output logic refresh_busy,
    output logic refresh_valid,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic cmd_dc
);
    localparam logic [19:0] REFRESH_LAST = 20'(REFRESH_CYCLES - 1);

    // ----------------------------------------
    // Link front end
    // ----------------------------------------
    link_if lnk ();

    link_rx u_rx (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .link_sclk(link_sclk),
        .link_sdin(link_sdin),
        .link_dc(link_dc),
        .link_rw(link_rw),
        .link_ce_n(link_ce_n),
        .rx(lnk.src)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic cal_mode;
        logic pend_shift;
        logic pend_bit;
        logic pend_cont;
        logic [8:0] sr;
        logic [1:0] hv_field;
        logic psave;
        logic busy;
        logic [19:0] cnt;
        logic refreshed;
        logic cmd_valid;
        logic [7:0] cmd_byte;
        logic cmd_dc;
    } ctl_state_t;

    ctl_state_t st_ff;
    ctl_state_t nxt_st;

    function automatic logic is_write_cmd(input logic dc, input logic rw);
        is_write_cmd = ~dc & ~rw;
    endfunction : is_write_cmd

    function automatic logic is_pwr_cmd(input logic [7:0] b);
        is_pwr_cmd = b[otp_cal_pkg::PWR_OPC_MSB:otp_cal_pkg::PWR_OPC_LSB] == otp_cal_pkg::PWR_OPCODE
                     && b[otp_cal_pkg::PWR_TAG_BIT];
    endfunction : is_pwr_cmd

    function automatic logic [8:0] shift_in(input logic [8:0] sr, input logic b);
        shift_in = {sr[otp_cal_pkg::SR_BITS-2:0], b};
    endfunction : shift_in

    // ----------------------------------------
    // Byte decode
    // ----------------------------------------
    logic byte_write;
    logic byte_entry;
    logic byte_exit_psave;
    logic byte_pwr;
    logic entry_allowed;
    logic refresh_done;

    assign byte_write = is_write_cmd(lnk.byte_dc, lnk.byte_rw);
    assign byte_entry = lnk.byte_data == otp_cal_pkg::CMD_CAL_ENTRY;
    assign byte_exit_psave = lnk.byte_data == otp_cal_pkg::CMD_EXIT_PSAVE;
    assign byte_pwr = is_pwr_cmd(lnk.byte_data);
    // Seal is only trustworthy once a refresh has loaded it
    assign entry_allowed = st_ff.refreshed && !st_ff.sr[otp_cal_pkg::SEAL_POS];
    // Last counted cycle of a refresh window
    assign refresh_done = st_ff.busy && st_ff.cnt == REFRESH_LAST;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // The extended-set pin is deliberately unread: both commands decode the same either way
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cmd_valid = 1'b0;
        // Counter runs beside command decoding, nothing waits on it
        if (st_ff.busy) begin
            nxt_st.cnt = st_ff.cnt + 20'h1;
            if (refresh_done) begin
                nxt_st.busy = 1'b0;
            end
        end
        if (lnk.byte_ok) begin
            if (st_ff.cal_mode) begin
                if (byte_write) begin
                    // Only the continuation and data bits matter here
                    nxt_st.pend_shift = 1'b1;
                    nxt_st.pend_bit = lnk.byte_data[otp_cal_pkg::DATA_BIT];
                    nxt_st.pend_cont = lnk.byte_data[otp_cal_pkg::CONT_BIT];
                end
            end else begin
                nxt_st.cmd_valid = 1'b1;
                nxt_st.cmd_byte = lnk.byte_data;
                nxt_st.cmd_dc = lnk.byte_dc;
                if (byte_write) begin
                    if (byte_entry) begin
                        if (entry_allowed) begin
                            nxt_st.cal_mode = 1'b1;
                            nxt_st.cmd_valid = 1'b0;
                        end
                    end else if (byte_exit_psave) begin
                        nxt_st.psave = 1'b0;
                        if (st_ff.psave) begin
                            nxt_st.busy = 1'b1;
                            nxt_st.cnt = '0;
                        end
                    end else if (byte_pwr) begin
                        nxt_st.hv_field = lnk.byte_data[otp_cal_pkg::PWR_FLD_MSB:otp_cal_pkg::PWR_FLD_LSB];
                        if (!st_ff.psave) begin
                            // A new command restarts the window, even in its last cycle
                            nxt_st.busy = 1'b1;
                            nxt_st.cnt = '0;
                        end
                    end
                end
            end
        end
        // Bit lands on the link clock fall that follows its byte
        if (st_ff.pend_shift && lnk.sclk_fall) begin
            nxt_st.pend_shift = 1'b0;
            // Earlier bits are only in place after all nine are
            nxt_st.sr = shift_in(st_ff.sr, st_ff.pend_bit);
            if (!st_ff.pend_cont) begin
                nxt_st.cal_mode = 1'b0;
            end
        end
        // Cell load comes last so it wins over a shift in the same cycle
        if (refresh_done) begin
            nxt_st.refreshed = 1'b1;
            nxt_st.sr = otp_cell_data;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset acts whether or not ce is high
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.cal_mode <= 1'b0;
            st_ff.sr <= otp_cal_pkg::SR_RESET;
            st_ff.hv_field <= otp_cal_pkg::HV_FIELD_RESET;
            st_ff.psave <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign calibration_entry_mode = st_ff.cal_mode;
    assign cal_load_en = st_ff.cal_mode;
    assign otp_prog_en = st_ff.cal_mode;
    assign lcd_voltage_offset_code = st_ff.sr[otp_cal_pkg::VOP_MSB:otp_cal_pkg::VOP_LSB];
    assign temp_coeff_default = st_ff.sr[otp_cal_pkg::TC_MSB:otp_cal_pkg::TC_LSB];
    assign seal_bit = st_ff.sr[otp_cal_pkg::SEAL_POS];
    assign cal_shift_reg = st_ff.sr;
    assign hv_gen_power_field = st_ff.hv_field;
    assign power_save = st_ff.psave;
    assign refresh_busy = st_ff.busy;
    assign refresh_valid = st_ff.refreshed;
    assign cmd_valid = st_ff.cmd_valid;
    assign cmd_byte = st_ff.cmd_byte;
    assign cmd_dc = st_ff.cmd_dc;
endmodule : otp_calibration_shift_control

// ### otp_cal_checker.sv
// Port checker for the calibration shift control block.
// Assumes otp_cell_data is steady while a refresh ends; refresh cycles count only while ce is high.
module otp_cal_checker #(
    parameter int REFRESH_CYCLES = otp_cal_pkg::REFRESH_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic calibration_entry_mode,
    input wire logic cal_load_en,
    input wire logic otp_prog_en,
    input wire logic [4:0] lcd_voltage_offset_code,
    input wire logic [2:0] temp_coeff_default,
    input wire logic seal_bit,
    input wire logic [8:0] cal_shift_reg,
    input wire logic [8:0] otp_cell_data,
    input wire logic [1:0] hv_gen_power_field,
    input wire logic power_save,
    input wire logic refresh_busy,
    input wire logic refresh_valid,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int R_LO = REFRESH_CYCLES - 1;
    localparam int R_HI = REFRESH_CYCLES + 1;
    logic [19:0] busy_cnt_ff;
    logic pwr_cmd;
    assign pwr_cmd = cmd_valid && cmd_byte[7:3] == otp_cal_pkg::PWR_OPCODE && cmd_byte[0];
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // One cycle of slack either way: the start edge of a refresh is not pinned down
    always_ff @(posedge clk_sys) begin
        if (srst || !refresh_busy) begin
            busy_cnt_ff <= 20'h0;
        end else if (ce) begin
            busy_cnt_ff <= busy_cnt_ff + 20'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_mode_outs; cal_load_en == calibration_entry_mode && otp_prog_en == calibration_entry_mode; endproperty
    a_mode_outs: assert property (p_mode_outs) else $error("enable outputs differ from mode");
    property p_fields; {lcd_voltage_offset_code, temp_coeff_default, seal_bit} == cal_shift_reg; endproperty
    a_fields: assert property (p_fields) else $error("field split wrong");
    property p_entry; $rose(calibration_entry_mode) |-> $past(refresh_valid) && !$past(seal_bit); endproperty
    a_entry: assert property (p_entry) else $error("entry while sealed or unrefreshed");
    property p_no_cmd; calibration_entry_mode |=> !cmd_valid; endproperty
    a_no_cmd: assert property (p_no_cmd) else $error("byte decoded in calibration");
    property p_shift; (calibration_entry_mode || $fell(calibration_entry_mode)) && $changed(cal_shift_reg)
        && !$past(refresh_busy) && !$past(srst) |-> cal_shift_reg[8:1] == $past(cal_shift_reg[7:0]); endproperty
    a_shift: assert property (p_shift) else $error("shift order wrong");
    property p_load; $fell(refresh_busy) |-> cal_shift_reg == $past(otp_cell_data) && refresh_valid; endproperty
    a_load: assert property (p_load) else $error("refresh did not load cells");
    property p_len; $fell(refresh_busy) |-> busy_cnt_ff >= R_LO && busy_cnt_ff <= R_HI; endproperty
    a_len: assert property (p_len) else $error("refresh length wrong");
    property p_psave; pwr_cmd && power_save |-> hv_gen_power_field == cmd_byte[2:1] && !refresh_busy; endproperty
    a_psave: assert property (p_psave) else $error("power-save command wrong");
    property p_pwr; pwr_cmd && !power_save |-> hv_gen_power_field == cmd_byte[2:1] && refresh_busy; endproperty
    a_pwr: assert property (p_pwr) else $error("power command gave no refresh");
endmodule : otp_cal_checker

// ### host_link_model.sv
// Host model: sends command and calibration bytes on the serial link.
// Assumes clk_sys at 5 ns; one link clock half period is 8 system cycles.
module host_link_model (
    input wire logic clk_sys,
    output logic link_sclk,
    output logic link_sdin,
    output logic link_dc,
    output logic link_rw,
    output logic link_ce_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        link_sclk = 1'b0;
        link_sdin = 1'b0;
        link_dc = 1'b1;
        link_rw = 1'b1;
        link_ce_n = 1'b1;
    end
    task automatic half;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : half
    // ----------------------------------------
    // Byte transfer, MSB first, always a write; dc low unless asked
    // ----------------------------------------
    task automatic send(input logic [7:0] b, input logic dc = 1'b0);
        link_ce_n = 1'b0;
        link_dc = dc;
        link_rw = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            link_sdin = b[i];
            half();
            link_sclk = 1'b1;
            half();
            link_sclk = 1'b0;
        end
        half();
        // Released lines flip so a late sample shows up
        link_sdin = ~b[0];
        link_dc = 1'b1;
        link_rw = 1'b1;
        link_ce_n = 1'b1;
        half();
    endtask : send
endmodule : host_link_model

// ### testbench.sv
// Self-checking bench for the calibration shift control block.
// Assumes the host model ends each byte after all outputs have settled.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 300;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ext_sel = 1'b0;
    logic ce = 1'b1;
    logic last_dc = 1'b0;
    localparam logic [8:0] CAL_WORD = 9'h1c4;
    logic [8:0] otp_cell_data = 9'h1a4;
    logic link_sclk, link_sdin, link_dc, link_rw, link_ce_n, mode, load_en, prog_en, seal, psave, busy, rvalid;
    logic cmd_valid, cmd_dc;
    logic [4:0] vop;
    logic [2:0] tc;
    logic [8:0] sr;
    logic [1:0] field;
    logic [7:0] cmd_byte;
    logic [7:0] last_cmd = 8'h00;
    int checks = 0;
    int bad_count = 0;
    int cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    otp_calibration_shift_control #(.REFRESH_CYCLES(RC)) DUT (.clk_sys, .srst, .ce, .link_sclk, .link_sdin,
        .link_dc, .link_rw, .link_ce_n, .extended_set_select(ext_sel), .otp_cell_data,
        .calibration_entry_mode(mode), .cal_load_en(load_en), .otp_prog_en(prog_en), .lcd_voltage_offset_code(vop),
        .temp_coeff_default(tc), .seal_bit(seal), .cal_shift_reg(sr), .hv_gen_power_field(field),
        .power_save(psave), .refresh_busy(busy), .refresh_valid(rvalid), .cmd_valid, .cmd_byte, .cmd_dc);
    host_link_model u_host (.clk_sys, .link_sclk, .link_sdin, .link_dc, .link_rw, .link_ce_n);
    // ----------------------------------------
    // Monitor, timeout and verdict
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cmd_valid === 1'b1) begin
            last_cmd <= cmd_byte;
            last_dc <= cmd_dc;
        end
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic wait_refresh;
        for (int i = 0; i < 2 * RC && busy !== 1'b0; i++) step(1);
        `CHK(busy, 1'b0)
    endtask : wait_refresh
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        step(16);
        srst = 1'b0;
        `CHK({sr, psave}, 10'h001)
        u_host.send(8'h82);
        `CHK({mode, last_cmd}, 9'h082)
        u_host.send(8'h2b);
        `CHK({field, busy}, 3'h2)
        u_host.send(8'he1);
        `CHK({psave, busy}, 2'h1)
        u_host.send(8'h00);
        `CHK({busy, last_cmd}, 9'h100)
        wait_refresh();
        `CHK({rvalid, sr}, 10'h3a4)
        ext_sel = 1'b1;
        u_host.send(8'h82);
        `CHK({mode, load_en, prog_en}, 3'h7)
        for (int i = 8; i >= 0; i--) begin
            u_host.send({i != 0, 6'h2a, CAL_WORD[i]});
            `CHK(mode, i != 0)
        end
        `CHK({vop, tc, seal}, 9'h1c4)
        `CHK(last_cmd, 8'h00)
        u_host.send(8'h82);
        u_host.send(8'h81);
        `CHK({mode, sr}, 10'h389)
        u_host.send(8'h00, 1'b1);
        `CHK({mode, sr}, 10'h389)
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        `CHK({mode, sr, psave}, 11'h001)
        u_host.send(8'h5a, 1'b1);
        `CHK({last_dc, last_cmd}, 9'h15a)
        otp_cell_data = 9'h001;
        u_host.send(8'he1);
        wait_refresh();
        u_host.send(8'h82);
        `CHK({seal, mode, last_dc, last_cmd}, 11'h482)
        u_host.send(8'h2d);
        `CHK({field, busy}, 3'h5)
        ce = 1'b0;
        step(RC + 20);
        `CHK({busy, field}, 3'h6)
        ce = 1'b1;
        wait_refresh();
        stop_test();
    end
endmodule : testbench
bind otp_calibration_shift_control otp_cal_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (.clk_sys, .srst, .ce,
    .calibration_entry_mode, .cal_load_en, .otp_prog_en, .lcd_voltage_offset_code, .temp_coeff_default, .seal_bit,
    .cal_shift_reg, .otp_cell_data, .hv_gen_power_field, .power_save, .refresh_busy, .refresh_valid, .cmd_valid,
    .cmd_byte);
